// ---- hdl/acl_adc_ctrl.sv ----
// Purpose: Setup word, limit registers, limit comparator and two-wire slave
// Assumes: Front end reports each result with a one-cycle conv_valid on mclk
// Notes: Bus pins are open drain; outputs are fixed low, enables drive
// Functional notes
// - Start bit write begins one shot when idle
// - Start bit reads zero while converting
// - Pair field selects input pair
// - Gain field selects full-scale range
// - Mode bit: zero continuous, one single shot
// - Rate field sets sample rate
// - Type bit: hysteresis or window comparator
// - Polarity bit sets alert active level
// - Unlatched alert releases inside window, or below lower limit in hysteresis
// - Latched alert held until result read or response
// - Response clears only lowest asserting address
// - Queue code 11 disables, pin high
// - Queue needs one, two or four results
// - Limits are 16-bit two's complement words
// - Upper msb one, lower zero: ready mode
// - Ready mode: status level or pulse
// - Low four limit bits ignored
// - Clock line never driven
// - Pointer low bits select register
// - Address from strap, sampled continuously
// - Result left-justified, zero after reset
module acl_adc_ctrl import acl_pkg::*; #(
  parameter int RDY_CYC = RDY_PULSE_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic alert_out,
  output logic alert_oe,
  input wire logic strap_bit_zero,
  input wire logic strap_bit_one,
  input wire logic [11:0] conv_data,
  input wire logic conv_valid,
  output logic conv_start,
  output logic conv_continuous,
  output logic [1:0] positive_input,
  output logic [2:0] negative_input,
  output logic [2:0] gain_range_select,
  output logic [2:0] sample_rate_select
);
  // ***************************************************
  // Functions
  // ***************************************************
  function automatic logic [2:0] q_need(input logic [1:0] q);
    q_need = (q == 2'h0) ? 3'h1 : ((q == 2'h1) ? 3'h2 : 3'h4);
  endfunction
  function automatic logic s_gt(input logic [15:0] a, input logic [15:0] b);
    s_gt = $signed(a[15:4]) > $signed(b[15:4]);
  endfunction

  // ***************************************************
  // Reset and pin synchronisers
  // ***************************************************
  logic [1:0] rst_sync_ff;
  logic rst_n;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) rst_sync_ff <= 2'h0;
    else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  // Clock line is only sampled, never driven, so no stretching is possible
  logic [2:0] scl_ff, sda_ff;
  logic [1:0] s0_ff, s1_ff;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_ff <= 3'h7;
      sda_ff <= 3'h7;
      s0_ff <= 2'h0;
      s1_ff <= 2'h0;
    end else begin
      scl_ff <= {scl_ff[1:0], scl_in};
      sda_ff <= {sda_ff[1:0], sda_in};
      s0_ff <= {s0_ff[0], strap_bit_zero};
      s1_ff <= {s1_ff[0], strap_bit_one};
    end
  end
  logic scl_s, sda_s, scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_s = scl_ff[1];
  assign sda_s = sda_ff[1];
  assign scl_rise = scl_s & ~scl_ff[2];
  assign scl_fall = ~scl_s & scl_ff[2];
  assign bus_start = scl_s & scl_ff[2] & ~sda_s & sda_ff[2];
  assign bus_stop = scl_s & scl_ff[2] & sda_s & ~sda_ff[2];
  logic [6:0] own_addr;
  assign own_addr = {OWN_ADDR_BASE, s1_ff[1], s0_ff[1]};

  // ***************************************************
  // Registers
  // ***************************************************
  logic [15:0] setup_ff, lower_ff, upper_ff, result_ff;
  logic busy_ff, conv_start_ff, soft_rst, wr_en, rd_clr, resp_clr;
  logic [1:0] ptr_ff;
  logic [7:0] wr_hi_ff, last_byte;
  logic single_mode, powered_down, ready_mode, cmp_off;
  assign single_mode = setup_ff[MODE_BIT];
  assign powered_down = single_mode & ~busy_ff;
  assign ready_mode = upper_ff[15] & ~lower_ff[15];
  assign cmp_off = (setup_ff[QUE_LSB+:2] == QUE_OFF);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      setup_ff <= SETUP_RST;
      lower_ff <= LOWER_RST;
      upper_ff <= UPPER_RST;
    end else if (soft_rst) begin
      setup_ff <= SETUP_RST;
      lower_ff <= LOWER_RST;
      upper_ff <= UPPER_RST;
    end else if (wr_en) begin
      unique case (ptr_ff)
        PTR_RESULT: ;
        PTR_SETUP: setup_ff <= {1'b1, wr_hi_ff[6:0], last_byte};
        PTR_LOWER: lower_ff <= {wr_hi_ff, last_byte};
        PTR_UPPER: upper_ff <= {wr_hi_ff, last_byte};
      endcase
    end
  end

  // Single-shot start: stored bit never holds, busy flag is the status
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      conv_start_ff <= 1'b0;
    end else begin
      conv_start_ff <= 1'b0;
      if (soft_rst) begin
        busy_ff <= 1'b0;
      end else if (wr_en && ptr_ff == PTR_SETUP && wr_hi_ff[7] && powered_down) begin
        busy_ff <= 1'b1;
        conv_start_ff <= 1'b1;
      end else if (conv_valid) begin
        busy_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) result_ff <= RESULT_RST;
    else if (soft_rst) result_ff <= RESULT_RST;
    else if (conv_valid) result_ff <= {conv_data, 4'h0};
  end

  logic ss_status;
  assign ss_status = single_mode & ~busy_ff;
  logic [15:0] rd_word;
  always_comb begin
    unique case (ptr_ff)
      PTR_RESULT: rd_word = result_ff;
      PTR_SETUP: rd_word = {ss_status, setup_ff[14:0]};
      PTR_LOWER: rd_word = lower_ff;
      PTR_UPPER: rd_word = upper_ff;
    endcase
  end

  // ***************************************************
  // Front-end controls
  // ***************************************************
  logic [2:0] pair;
  assign pair = setup_ff[PAIR_LSB+:3];
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      positive_input <= 2'h0;
      negative_input <= 3'h1;
      gain_range_select <= 3'h2;
      sample_rate_select <= 3'h4;
      conv_continuous <= 1'b0;
    end else begin
      unique case (pair)
        3'h0: begin positive_input <= 2'h0; negative_input <= 3'h1; end
        3'h1: begin positive_input <= 2'h0; negative_input <= 3'h3; end
        3'h2: begin positive_input <= 2'h1; negative_input <= 3'h3; end
        3'h3: begin positive_input <= 2'h2; negative_input <= 3'h3; end
        default: begin positive_input <= pair[1:0]; negative_input <= NEG_GND; end
      endcase
      gain_range_select <= (setup_ff[GAIN_LSB+:3] > 3'h5) ? 3'h5 : setup_ff[GAIN_LSB+:3];
      sample_rate_select <= (setup_ff[RATE_LSB+:3] > 3'h6) ? 3'h6 : setup_ff[RATE_LSB+:3];
      conv_continuous <= ~single_mode;
    end
  end
  assign conv_start = conv_start_ff;

  // ***************************************************
  // Limit comparator
  // ***************************************************
  logic alert_ff;
  logic [2:0] q_cnt_ff;
  logic above, below, beyond, q_hit;
  assign above = s_gt(result_ff, upper_ff);
  assign below = s_gt(lower_ff, result_ff);
  assign beyond = setup_ff[CTYPE_BIT] ? (above | below) : above;
  assign q_hit = (q_cnt_ff + 3'h1) >= q_need(setup_ff[QUE_LSB+:2]);
  // Decision uses the result one cycle after conv_valid, once it is stored
  logic eval_ff;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) eval_ff <= 1'b0;
    else eval_ff <= conv_valid;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      alert_ff <= 1'b0;
      q_cnt_ff <= 3'h0;
    end else if (soft_rst || cmp_off || ready_mode) begin
      alert_ff <= 1'b0;
      q_cnt_ff <= 3'h0;
    end else if (eval_ff && beyond) begin
      if (!q_hit) q_cnt_ff <= q_cnt_ff + 3'h1;
      if (q_hit) alert_ff <= 1'b1;
    end else if (eval_ff) begin
      q_cnt_ff <= 3'h0;
      if (!setup_ff[LAT_BIT] && (setup_ff[CTYPE_BIT] || below)) alert_ff <= 1'b0;
      else if (setup_ff[LAT_BIT] && (rd_clr || resp_clr)) alert_ff <= 1'b0;
    end else if (setup_ff[LAT_BIT] && (rd_clr || resp_clr)) begin
      alert_ff <= 1'b0;
    end
  end

  // Ready pulse length trades visibility against the fastest rate
  logic [15:0] rdy_cnt_ff;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) rdy_cnt_ff <= 16'h0000;
    else if (conv_valid && !single_mode) rdy_cnt_ff <= 16'(RDY_CYC);
    else if (rdy_cnt_ff != 16'h0000) rdy_cnt_ff <= rdy_cnt_ff - 16'h0001;
  end
  logic asserted, pin_level;
  assign asserted = ready_mode ? (single_mode ? ss_status : (rdy_cnt_ff != 16'h0000)) : alert_ff;
  assign pin_level = cmp_off ? 1'b1 : (setup_ff[POL_BIT] ? asserted : ~asserted);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) alert_oe <= 1'b0;
    else alert_oe <= ~pin_level;
  end
  assign alert_out = 1'b0;
  assign sda_out = 1'b0;

  // ***************************************************
  // Two-wire slave
  // ***************************************************
  acl_bus_e st_ff;
  logic [7:0] sh_ff;
  logic [3:0] bit_cnt_ff;
  logic [1:0] byte_idx_ff;
  logic is_rd_ff, is_resp_ff, is_gc_ff, sda_oe_ff, soft_rst_ff, wr_en_ff, rd_clr_ff, resp_clr_ff;
  logic [7:0] tx_byte;
  assign last_byte = sh_ff;
  // Loaded only at the address ack, so a plain read always opens with the msb
  assign tx_byte = is_resp_ff ? {own_addr, 1'b0} : rd_word[15:8];
  assign soft_rst = soft_rst_ff;
  assign wr_en = wr_en_ff;
  assign rd_clr = rd_clr_ff;
  assign resp_clr = resp_clr_ff;
  assign sda_oe = sda_oe_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= ST_IDLE;
      sh_ff <= 8'h00;
      bit_cnt_ff <= 4'h0;
      byte_idx_ff <= 2'h0;
      is_rd_ff <= 1'b0;
      is_resp_ff <= 1'b0;
      is_gc_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      ptr_ff <= PTR_RESULT;
      wr_hi_ff <= 8'h00;
      soft_rst_ff <= 1'b0;
      wr_en_ff <= 1'b0;
      rd_clr_ff <= 1'b0;
      resp_clr_ff <= 1'b0;
    end else begin
      soft_rst_ff <= 1'b0;
      wr_en_ff <= 1'b0;
      rd_clr_ff <= 1'b0;
      resp_clr_ff <= 1'b0;
      if (bus_start) begin
        st_ff <= ST_RX;
        bit_cnt_ff <= 4'h0;
        byte_idx_ff <= 2'h0;
        sda_oe_ff <= 1'b0;
      end else if (bus_stop) begin
        st_ff <= ST_IDLE;
        sda_oe_ff <= 1'b0;
      end else begin
        unique case (st_ff)
          ST_IDLE: ;
          ST_RX: begin
            if (scl_rise) begin
              sh_ff <= {sh_ff[6:0], sda_s};
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end else if (scl_fall && bit_cnt_ff == 4'h8) begin
              bit_cnt_ff <= 4'h0;
              st_ff <= ST_RACK;
              sda_oe_ff <= 1'b1;
              if (byte_idx_ff == 2'h0) begin
                is_rd_ff <= sh_ff[0];
                is_resp_ff <= 1'b0;
                is_gc_ff <= 1'b0;
                if (sh_ff[7:1] == own_addr) begin
                end else if (sh_ff == {ALERT_RESP_ADDR, 1'b1} && alert_ff) begin
                  is_resp_ff <= 1'b1;
                end else if (sh_ff == {GC_ADDR, 1'b0}) begin
                  is_gc_ff <= 1'b1;
                end else begin
                  st_ff <= ST_IDLE;
                  sda_oe_ff <= 1'b0;
                end
              end else if (is_gc_ff) begin
                soft_rst_ff <= (byte_idx_ff == 2'h1) && (sh_ff == GC_RESET_CMD);
              end else if (byte_idx_ff == 2'h1) begin
                ptr_ff <= sh_ff[1:0];
              end else if (byte_idx_ff == 2'h2) begin
                wr_hi_ff <= sh_ff;
              end else begin
                wr_en_ff <= 1'b1;
              end
            end
          end
          ST_RACK: begin
            if (scl_fall) begin
              if (byte_idx_ff != 2'h3) byte_idx_ff <= byte_idx_ff + 2'h1;
              if (is_rd_ff) begin
                sh_ff <= tx_byte;
                sda_oe_ff <= ~tx_byte[7];
                st_ff <= ST_TX;
              end else begin
                sda_oe_ff <= 1'b0;
                st_ff <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
              if (is_resp_ff && sh_ff[7] && !sda_s) begin
                st_ff <= ST_IDLE;
                sda_oe_ff <= 1'b0;
              end
            end else if (scl_fall) begin
              if (bit_cnt_ff == 4'h8) begin
                sda_oe_ff <= 1'b0;
                bit_cnt_ff <= 4'h0;
                st_ff <= ST_TACK;
              end else begin
                sh_ff <= {sh_ff[6:0], 1'b0};
                sda_oe_ff <= ~sh_ff[6];
              end
            end
          end
          ST_TACK: begin
            if (scl_rise) begin
              resp_clr_ff <= is_resp_ff;
              rd_clr_ff <= ~is_resp_ff && (ptr_ff == PTR_RESULT) && (byte_idx_ff == 2'h1);
              if (sda_s || is_resp_ff || byte_idx_ff == 2'h2) st_ff <= ST_IDLE;
              else st_ff <= ST_TNEXT;
            end
          end
          ST_TNEXT: begin
            if (scl_fall) begin
              byte_idx_ff <= 2'h2;
              sh_ff <= rd_word[7:0];
              sda_oe_ff <= ~rd_word[7];
              st_ff <= ST_TX;
            end
          end
          default: st_ff <= ST_IDLE;
        endcase
      end
    end
  end
endmodule

// ---- include/acl_pkg.sv ----
// Purpose: Shared constants for the converter setup and limit alert block
// Assumes: 200 MHz mclk
// Notes: Pointer codes, field positions and reset values of the register set
package acl_pkg;
  // ***************************************************
  // Timing
  // ***************************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int RDY_PULSE_NS = 8000;
  localparam int RDY_PULSE_CYC = (RDY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ***************************************************
  // Bus addresses and commands
  // ***************************************************
  localparam logic [4:0] OWN_ADDR_BASE = 5'h12;
  localparam logic [6:0] GC_ADDR = 7'h00;
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;
  localparam logic [7:0] GC_RESET_CMD = 8'h06;
  // ***************************************************
  // Pointer codes
  // ***************************************************
  localparam logic [1:0] PTR_RESULT = 2'h0;
  localparam logic [1:0] PTR_SETUP = 2'h1;
  localparam logic [1:0] PTR_LOWER = 2'h2;
  localparam logic [1:0] PTR_UPPER = 2'h3;
  // ***************************************************
  // Setup word fields
  // ***************************************************
  localparam int SS_BIT = 15;
  localparam int PAIR_LSB = 12;
  localparam int GAIN_LSB = 9;
  localparam int MODE_BIT = 8;
  localparam int RATE_LSB = 5;
  localparam int CTYPE_BIT = 4;
  localparam int POL_BIT = 3;
  localparam int LAT_BIT = 2;
  localparam int QUE_LSB = 0;
  localparam logic [1:0] QUE_OFF = 2'h3;
  localparam logic [2:0] NEG_GND = 3'h4;
  // ***************************************************
  // Reset values
  // ***************************************************
  localparam logic [15:0] SETUP_RST = 16'h8583;
  localparam logic [15:0] LOWER_RST = 16'h8000;
  localparam logic [15:0] UPPER_RST = 16'h7FFF;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_RACK = 3'b010,
    ST_TX = 3'b011,
    ST_TACK = 3'b100,
    ST_TNEXT = 3'b101
  } acl_bus_e;
endpackage

// ---- tb/acl_checker.sv ----
// Purpose: Port-level checks on the converter control block
// Assumes: One mclk domain, resetn active low
// Notes: Bound to every instance of the block
module acl_checker (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_oe,
  input wire logic alert_oe,
  input wire logic conv_valid,
  input wire logic conv_start,
  input wire logic conv_continuous,
  input wire logic [1:0] positive_input,
  input wire logic [2:0] negative_input,
  input wire logic [2:0] gain_range_select,
  input wire logic [2:0] sample_rate_select
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ****************
  // Checks
  // ****************
  gain_fold_a: assert property (gain_range_select <= 3'h5) else $error("gain code out of range");
  rate_fold_a: assert property (sample_rate_select != 3'h7) else $error("rate code out of range");
  pair_map_a: assert property (negative_input == 3'h1 ? positive_input == 2'h0 :
    (negative_input == 3'h3 ? positive_input != 2'h3 : negative_input == 3'h4)) else $error("bad input pair");
  start_once_a: assert property (conv_start |=> !conv_start) else $error("start pulse too long");
  start_bus_a: assert property (conv_start |-> !scl_in && $past(!scl_in, 2)) else $error("start off bus");
  cont_start_a: assert property (conv_continuous && $past(conv_continuous, 3) |-> !conv_start)
    else $error("start while continuous");
  sda_lowclk_a: assert property ($changed(sda_oe) |-> !scl_in) else $error("data moved with clock high");
  alert_cause_a: assert property ($rose(alert_oe) |-> !scl_in || $past(conv_valid, 2) ||
    $past(conv_valid, 3) || $past(conv_valid, 4)) else $error("alert without cause");
  reset_vals_a: assert property ($rose(resetn) |-> (!alert_oe && !sda_oe && !conv_start &&
    negative_input == 3'h1 && gain_range_select == 3'h2 && sample_rate_select == 3'h4)[*3])
    else $error("wrong state after reset");
  start_c: cover property (conv_start);
  alert_c: cover property ($rose(alert_oe));
  cont_c: cover property ($rose(conv_continuous));
endmodule
bind acl_adc_ctrl acl_checker chk (.*);

// ---- tb/acl_host_model.sv ----
// Purpose: Two-wire bus host that drives the clock and data lines of the block
// Assumes: Data line has a pull-up; the bench resolves its level from both drivers
// Notes: Clock stands high between frames; one bit takes 25 mclk cycles
module acl_host_model (
  input wire logic mclk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic q(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic start();
    sda_low = 1'b0;
    q(6);
    scl = 1'b1;
    q(6);
    sda_low = 1'b1;
    q(6);
    scl = 1'b0;
    q(7);
  endtask
  task automatic stop();
    sda_low = 1'b1;
    q(6);
    scl = 1'b1;
    q(6);
    sda_low = 1'b0;
    q(12);
  endtask
  // Data only moves while the clock is low, so it never looks like a start or stop
  task automatic bit_x(input logic b, output logic r);
    sda_low = ~b;
    q(6);
    scl = 1'b1;
    q(6);
    r = sda;
    q(6);
    scl = 1'b0;
    q(7);
  endtask
  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(v[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic mack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      v[i] = r;
    end
    bit_x(~mack, r);
  endtask
endmodule

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for the converter setup and limit alert block
// Assumes: Host model drives the bus; the bench plays the converter front end
// Notes: Ready pulse shortened to 20 cycles to keep the run short
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module tb_top import acl_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic resetn, scl, sda_low, s0, s1, conv_valid, a;
  logic [11:0] conv_data;
  logic sda_oe, sda_out, alert_oe, alert_out, conv_start, conv_continuous;
  logic [1:0] positive_input;
  logic [2:0] negative_input, gain_range_select, sample_rate_select;
  logic [6:0] dev;
  logic [7:0] d;
  int failures = 0, comparisons = 0, starts = 0, n;
  logic [4:0] pair_tab [4] = '{5'h01, 5'h03, 5'h0B, 5'h13};
  logic [17:0] vec [18] = '{{5'h00, 12'h300, 1'b1}, {5'h00, 12'h180, 1'b1}, {5'h00, 12'h050, 1'b0},
    {5'h10, 12'h050, 1'b1}, {5'h10, 12'h180, 1'b0}, {5'h10, 12'h100, 1'b0},
    {5'h10, 12'h300, 1'b1}, {5'h18, 12'h300, 1'b0}, {5'h18, 12'h180, 1'b1},
    {5'h11, 12'h300, 1'b0}, {5'h11, 12'h300, 1'b1}, {5'h12, 12'h180, 1'b0},
    {5'h12, 12'h300, 1'b0}, {5'h12, 12'h300, 1'b0}, {5'h12, 12'h300, 1'b0},
    {5'h12, 12'h300, 1'b1}, {5'h14, 12'h300, 1'b1}, {5'h14, 12'h180, 1'b1}};
  // Pull-up on the data line: high unless someone pulls it low
  wire logic sda = ~(sda_oe | sda_low);
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) if (conv_start === 1'b1) starts++;
  acl_adc_ctrl #(.RDY_CYC(20)) DUT (.mclk(mclk), .resetn(resetn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .alert_out(alert_out), .alert_oe(alert_oe), .strap_bit_zero(s0), .strap_bit_one(s1),
    .conv_data(conv_data), .conv_valid(conv_valid), .conv_start(conv_start), .conv_continuous(conv_continuous),
    .positive_input(positive_input), .negative_input(negative_input), .gain_range_select(gain_range_select),
    .sample_rate_select(sample_rate_select));
  acl_host_model host (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));
  // ****************
  // Tasks
  // ****************
  task automatic test_done();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [15:0] su(logic ss, logic md, logic [4:0] cf);
    return {ss, 3'h0, 3'h2, md, 3'h4, cf};
  endfunction
  task automatic wr(input logic [1:0] p, input logic [15:0] v);
    logic [3:0] k;
    host.start();
    host.wbyte({dev, 1'b0}, k[3]);
    host.wbyte({6'h00, p}, k[2]);
    host.wbyte(v[15:8], k[1]);
    host.wbyte(v[7:0], k[0]);
    host.stop();
    `CHK(k, 4'hF)
  endtask
  task automatic rd(input logic [1:0] p, input logic [15:0] e);
    logic [2:0] k;
    logic [15:0] v;
    host.start();
    host.wbyte({dev, 1'b0}, k[2]);
    host.wbyte({6'h00, p}, k[1]);
    host.start();
    host.wbyte({dev, 1'b1}, k[0]);
    host.rbyte(1'b1, v[15:8]);
    host.rbyte(1'b0, v[7:0]);
    host.stop();
    `CHK({k, v}, {3'h7, e})
  endtask
  task automatic conv(input logic [11:0] v);
    @(negedge mclk);
    conv_data = v;
    conv_valid = 1'b1;
    @(negedge mclk);
    conv_valid = 1'b0;
    repeat (6) @(negedge mclk);
  endtask
  // ****************
  // Sequence
  // ****************
  initial begin
    repeat (95000) @(posedge mclk);
    failures++;
    test_done();
  end
  initial begin
    resetn = 1'b0;
    {s1, s0, conv_valid} = 3'h0;
    conv_data = 12'h000;
    dev = 7'h48;
    repeat (5) @(negedge mclk);
    resetn = 1'b1;
    repeat (8) @(negedge mclk);
    `CHK({alert_oe, sda_oe, positive_input, negative_input, gain_range_select, sample_rate_select}, 13'h0054)
    rd(PTR_SETUP, 16'h8583);
    rd(PTR_LOWER, 16'h8000);
    rd(PTR_UPPER, 16'h7FFF);
    rd(PTR_RESULT, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      {s1, s0} = 2'(i);
      dev = {5'h12, 2'(i)};
      rd(PTR_UPPER, 16'h7FFF);
    end
    host.start();
    host.wbyte(8'h98, a);
    host.stop();
    `CHK(a, 1'b0)
    for (int i = 0; i < 8; i++) begin
      wr(PTR_SETUP, {1'b0, 3'(i), 3'(i), 1'b1, 3'(i), 5'h03});
      `CHK({positive_input, negative_input}, i < 4 ? pair_tab[i] : {2'(i), 3'h4})
      `CHK(gain_range_select, i > 5 ? 3'h5 : 3'(i))
      `CHK(sample_rate_select, i > 6 ? 3'h6 : 3'(i))
    end
    n = starts;
    wr(PTR_SETUP, su(1'b0, 1'b1, 5'h03));
    `CHK(starts, n)
    wr(PTR_SETUP, su(1'b1, 1'b1, 5'h03));
    rd(PTR_SETUP, su(1'b0, 1'b1, 5'h03));
    wr(PTR_SETUP, su(1'b1, 1'b1, 5'h03));
    conv(12'hABC);
    rd(PTR_RESULT, 16'hABC0);
    rd(PTR_SETUP, su(1'b1, 1'b1, 5'h03));
    wr(PTR_SETUP, su(1'b0, 1'b0, 5'h03));
    wr(PTR_SETUP, su(1'b1, 1'b0, 5'h03));
    `CHK(starts, n + 1)
    `CHK(conv_continuous, 1'b1)
    rd(PTR_SETUP, su(1'b0, 1'b0, 5'h03));
    // Low nibbles set: only the upper twelve bits may count
    wr(PTR_LOWER, 16'h100F);
    wr(PTR_UPPER, 16'h200F);
    rd(PTR_LOWER, 16'h100F);
    for (int i = 0; i < 18; i++) begin
      if (i == 0 || vec[i][17:13] != vec[i-1][17:13])
        wr(PTR_SETUP, su(1'b0, 1'b0, vec[i][17:13]));
      conv(vec[i][12:1]);
      `CHK(alert_oe, vec[i][0])
    end
    rd(PTR_RESULT, 16'h1800);
    `CHK(alert_oe, 1'b0)
    conv(12'h300);
    `CHK(alert_oe, 1'b1)
    // A lower address wins the response byte; this block must back off and keep its alert
    host.start();
    host.wbyte(8'h19, a);
    host.wbyte(8'h90, d[0]);
    host.stop();
    `CHK({a, d[0], alert_oe}, 3'b101)
    host.start();
    host.wbyte(8'h19, a);
    host.rbyte(1'b0, d);
    host.stop();
    `CHK({a, d}, {1'b1, dev, 1'b0})
    `CHK(alert_oe, 1'b0)
    wr(PTR_UPPER, 16'h8000);
    wr(PTR_LOWER, 16'h0000);
    wr(PTR_SETUP, su(1'b0, 1'b0, 5'h00));
    conv(12'h100);
    `CHK(alert_oe, 1'b1)
    repeat (20) @(negedge mclk);
    `CHK(alert_oe, 1'b0)
    wr(PTR_SETUP, su(1'b0, 1'b1, 5'h00));
    `CHK(alert_oe, 1'b1)
    wr(PTR_SETUP, su(1'b1, 1'b1, 5'h00));
    `CHK(alert_oe, 1'b0)
    conv(12'h100);
    `CHK(alert_oe, 1'b1)
    // General call reset returns every register except the pointer to its power-up value
    host.start();
    host.wbyte(8'h00, a);
    host.wbyte(GC_RESET_CMD, d[0]);
    host.stop();
    `CHK({a, d[0], alert_oe, alert_out, sda_out}, 5'b11000)
    rd(PTR_SETUP, 16'h8583);
    rd(PTR_LOWER, 16'h8000);
    rd(PTR_UPPER, 16'h7FFF);
    rd(PTR_RESULT, 16'h0000);
    test_done();
  end
endmodule
